// ===== rtl/aodt_decoder.sv
/*
  Arithmetic opcode decoder with execution timing. Takes opcode bytes
  from the prefetch stream, gathers modrm, displacement and immediate
  bytes, and issues one decoded word with its clock count.
  Assumes the prefetch queue holds a byte while byteValid and !byteReady.
*/
// Functional notes
// - Extra, code, stack and data segment override bytes redirect the next operand segment and cost two clocks each.
// - Add decodes from register form, immediate group with reg field zero, and accumulator form.
// - Add-with-carry decodes from its three forms; the immediate form costs 4 clocks on a register and 16 on memory.
// - Subtract decodes from its three forms; the accumulator form costs 3 clocks at byte and 4 at word width.
// - Subtract with borrow decodes from its three forms and uses the carry flag as the borrow input.
// - Negate decodes from the unary group with reg field three and costs 3 clocks on a register, 10 on memory.
// - The unpacked BCD fix after add is one byte and costs 8 clocks.
// - The packed BCD fix after add is one byte and costs 4 clocks.
// - The unpacked BCD fix after subtract is one byte and costs 7 clocks.
// - The packed BCD fix after subtract is one byte and costs 4 clocks.
// - Unsigned multiply decodes from the unary group with reg field four; register byte 26-28, word 35-37 clocks.
// - Unsigned multiply on memory costs 32-34 clocks at byte and 41-43 at word width.
`timescale 1ns/1ps
`default_nettype none
module aodt_decoder
  import aodt_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [7:0]  byteData,
  input  wire logic        byteValid,
  output logic             byteReady,
  output aodt_instr_t      instr,
  output logic             instrValid,
  output logic             busy,
  output logic             execDone
);

  aodt_state_t stReg,       stNext;
  aodt_instr_t curReg,      curNext;
  aodt_instr_t instrReg,    instrNext;
  logic        validReg,    validNext;
  logic [1:0]  dispLeftReg, dispLeftNext;
  logic [1:0]  immLeftReg,  immLeftNext;
  logic        hiByteReg,   hiByteNext;
  logic        segPendReg,  segPendNext;
  aodt_seg_t   segSelReg,   segSelNext;
  logic        take;
  logic        issue;
  logic        prefixTake;
  logic [CLK_W-1:0] loadCount;

  assign take      = byteValid && byteReady;
  assign byteReady = !busy; // stall the queue while an op executes

  // ------------------------------------------------------------------
  // byte gathering
  // ------------------------------------------------------------------
  always_comb
  begin
    stNext       = stReg;
    curNext      = curReg;
    instrNext    = instrReg;
    validNext    = 1'b0;
    dispLeftNext = dispLeftReg;
    immLeftNext  = immLeftReg;
    hiByteNext   = hiByteReg;
    segPendNext  = segPendReg;
    segSelNext   = segSelReg;
    prefixTake   = 1'b0;
    issue        = 1'b0;
    if (take)
    begin
      case (stReg)
        stOpcode:
        begin
          curNext          = '0;
          curNext.opcode   = byteData;
          curNext.wide     = byteData[0];
          curNext.toReg    = byteData[1];
          curNext.segValid = segPendReg;
          curNext.seg      = segSelReg;
          hiByteNext       = 1'b0;
          if (byteData == OPC_SEG_EXTRA || byteData == OPC_SEG_CODE ||
              byteData == OPC_SEG_STACK || byteData == OPC_SEG_DATA)
          begin
            prefixTake  = 1'b1;
            segPendNext = 1'b1;
            segSelNext  = aodt_seg_t'(byteData[4:3]);
          end
          else if (byteData == OPC_UBCD_ADD || byteData == OPC_PBCD_ADD ||
                   byteData == OPC_UBCD_SUB || byteData == OPC_PBCD_SUB)
          begin
            curNext.form = fmSingle;
            curNext.wide = 1'b0;
            case (byteData)
              OPC_UBCD_ADD: curNext.op = opUnpackedBcdFixAfterAdd;
              OPC_PBCD_ADD: curNext.op = opPackedBcdFixAfterAdd;
              OPC_UBCD_SUB: curNext.op = opUnpackedBcdFixAfterSub;
              default:      curNext.op = opPackedBcdFixAfterSub;
            endcase
            issue = 1'b1;
          end
          else if (byteData[7:2] == REG_ADD || byteData[7:2] == REG_ADC ||
                   byteData[7:2] == REG_SUB || byteData[7:2] == REG_SUBB)
          begin
            curNext.form = fmRegRm;
            case (byteData[7:2])
              REG_ADD:  curNext.op = opAdd;
              REG_ADC:  curNext.op = opAddCarry;
              REG_SUB:  curNext.op = opSub;
              default:  curNext.op = opSubtractionWithBorrowIn;
            endcase
            stNext = stModrm;
          end
          else if (byteData[7:2] == IMM_GROUP)
          begin
            curNext.form = fmImmGroup;
            stNext       = stModrm;
          end
          else if (byteData[7:1] == ACC_ADD || byteData[7:1] == ACC_ADC ||
                   byteData[7:1] == ACC_SUB || byteData[7:1] == ACC_SUBB)
          begin
            curNext.form = fmAccum;
            case (byteData[7:1])
              ACC_ADD: curNext.op = opAdd;
              ACC_ADC: curNext.op = opAddCarry;
              ACC_SUB: curNext.op = opSub;
              default: curNext.op = opSubtractionWithBorrowIn;
            endcase
            immLeftNext = byteData[0] ? 2'h2 : 2'h1;
            stNext      = stImm;
          end
          else if (byteData[7:1] == UNARY_GROUP)
          begin
            curNext.form = fmUnary;
            stNext       = stModrm;
          end
          else
            issue = 1'b1; // foreign opcode: one clock, no operand bytes
        end
        stModrm:
        begin
          curNext.modrm      = byteData;
          curNext.memOperand = (byteData[7:6] != MOD_REGISTER);
          if (curReg.form == fmImmGroup)
          begin
            case (byteData[5:3])
              SEL_ADD:  curNext.op = opAdd;
              SEL_ADC:  curNext.op = opAddCarry;
              SEL_SUB:  curNext.op = opSub;
              SEL_SUBB: curNext.op = opSubtractionWithBorrowIn;
              default:  curNext.op = opNone;
            endcase
            // short form for sign-extended words carries one byte
            immLeftNext = (curReg.wide && !curReg.opcode[1]) ?
                          2'h2 : 2'h1;
          end
          else if (curReg.form == fmUnary)
          begin
            case (byteData[5:3])
              SEL_NEGATE:   curNext.op = opTwosComplementNegate;
              SEL_MULTIPLY: curNext.op = opUnsignedMultiply;
              default:      curNext.op = curReg.op;
            endcase
            // test-immediate shares the group; keep the stream aligned
            immLeftNext = (byteData[5:3] == SEL_ADD ||
                           byteData[5:3] == SEL_TEST) ?
                          (curReg.wide ? 2'h2 : 2'h1) : 2'h0;
          end
          else
            immLeftNext = 2'h0;
          if (byteData[7:6] == MOD_DISP8)
            dispLeftNext = 2'h1;
          else if (byteData[7:6] == MOD_DISP16 ||
                   (byteData[7:6] == 2'h0 && byteData[2:0] == RM_DIRECT))
            dispLeftNext = 2'h2;
          else
            dispLeftNext = 2'h0;
          if (dispLeftNext != 2'h0)
            stNext = stDisp;
          else if (immLeftNext != 2'h0)
            stNext = stImm;
          else
            issue = 1'b1;
        end
        stDisp:
        begin
          // a lone displacement byte is sign-extended to a word
          if (hiByteReg)
            curNext.disp[15:8] = byteData;
          else
            curNext.disp = {{8{byteData[7]}}, byteData};
          hiByteNext   = !hiByteReg;
          dispLeftNext = dispLeftReg - 2'h1;
          if (dispLeftReg == 2'h1)
          begin
            hiByteNext = 1'b0;
            if (immLeftReg != 2'h0)
              stNext = stImm;
            else
              issue = 1'b1;
          end
        end
        stImm:
        begin
          if (hiByteReg)
            curNext.imm[15:8] = byteData;
          else if (curReg.form == fmImmGroup && curReg.opcode[1])
            curNext.imm = {{8{byteData[7]}}, byteData};
          else
            curNext.imm = {8'h00, byteData};
          hiByteNext  = !hiByteReg;
          immLeftNext = immLeftReg - 2'h1;
          if (immLeftReg == 2'h1)
            issue = 1'b1;
        end
        default: stNext = stOpcode;
      endcase
    end
    if (issue)
    begin
      curNext.useCarry      = (curNext.op == opAddCarry) ||
                              (curNext.op == opSubtractionWithBorrowIn);
      curNext.carryIsBorrow = (curNext.op == opSubtractionWithBorrowIn);
      curNext     = applyTiming(curNext);
      instrNext   = curNext;
      validNext   = 1'b1;
      stNext      = stOpcode;
      hiByteNext  = 1'b0;
      segPendNext = 1'b0; // override lasts for one instruction
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stReg       <= stOpcode;
      curReg      <= '0;
      instrReg    <= '0;
      validReg    <= 1'b0;
      dispLeftReg <= 2'h0;
      immLeftReg  <= 2'h0;
      hiByteReg   <= 1'b0;
      segPendReg  <= 1'b0;
      segSelReg   <= segExtra;
    end
    else
    begin
      stReg       <= stNext;
      curReg      <= curNext;
      instrReg    <= instrNext;
      validReg    <= validNext;
      dispLeftReg <= dispLeftNext;
      immLeftReg  <= immLeftNext;
      hiByteReg   <= hiByteNext;
      segPendReg  <= segPendNext;
      segSelReg   <= segSelNext;
    end
  end

  // ------------------------------------------------------------------
  // execution timing
  // ------------------------------------------------------------------
  assign loadCount = prefixTake ? CLK_SEG_PREFIX : curNext.clkMax;

  aodt_exec_timer #(
    .WIDTH (CLK_W)
  ) uTimer (
    .clock  (clock),
    .arst_n (arst_n),
    .load   (issue || prefixTake),
    .count  (loadCount),
    .busy   (busy),
    .done   (execDone)
  );

  assign instr      = instrReg;
  assign instrValid = validReg;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  prefix_two_clocks_a: assert property (
    prefixTake |=> busy [*2] ##1 !busy)
    else $error("segment prefix did not take two clocks");
  add_forms_a: assert property (
    instrValid && instr.opcode[7:2] == REG_ADD |->
    instr.op == opAdd && instr.clkMax == (instr.memOperand ? 10 : 3))
    else $error("add register form misdecoded");
  adc_imm_time_a: assert property (
    instrValid && instr.op == opAddCarry && instr.form == fmImmGroup |->
    instr.modrm[5:3] == 3'h2 && instr.clkMax == (instr.memOperand ? 16 : 4))
    else $error("add-with-carry immediate timing wrong");
  sub_accum_a: assert property (
    instrValid && instr.opcode[7:1] == ACC_SUB |->
    instr.op == opSub && instr.clkMax == (instr.wide ? 4 : 3))
    else $error("subtract accumulator form wrong");
  borrow_carry_a: assert property (
    instrValid && instr.op == opSubtractionWithBorrowIn |->
    instr.useCarry && instr.carryIsBorrow)
    else $error("borrow subtract ignores carry");
  negate_time_a: assert property (
    instrValid && instr.op == opTwosComplementNegate |->
    instr.modrm[5:3] == 3'h3 && instr.clkMax == (instr.memOperand ? 10 : 3))
    else $error("negate misdecoded");
  ubcd_add_a: assert property (
    take && stReg == stOpcode && byteData == 8'h37 |=>
    instrValid && instr.clkMax == 8 ##1 busy [*7] ##1 !busy)
    else $error("unpacked fix after add timing wrong");
  pbcd_add_a: assert property (
    take && stReg == stOpcode && byteData == 8'h27 |=>
    instrValid && instr.op == opPackedBcdFixAfterAdd && instr.clkMax == 4)
    else $error("packed fix after add wrong");
  ubcd_sub_a: assert property (
    take && stReg == stOpcode && byteData == 8'h3f |=>
    instrValid && instr.op == opUnpackedBcdFixAfterSub && instr.clkMax == 7)
    else $error("unpacked fix after subtract wrong");
  pbcd_sub_a: assert property (
    take && stReg == stOpcode && byteData == 8'h2f |=>
    instrValid && instr.op == opPackedBcdFixAfterSub && instr.clkMax == 4)
    else $error("packed fix after subtract wrong");
  mpy_reg_a: assert property (
    instrValid && instr.op == opUnsignedMultiply && !instr.memOperand |->
    instr.clkMin == (instr.wide ? 35 : 26) &&
    instr.clkMax == (instr.wide ? 37 : 28))
    else $error("register multiply timing wrong");
  mpy_mem_a: assert property (
    instrValid && instr.op == opUnsignedMultiply && instr.memOperand |->
    instr.clkMin == (instr.wide ? 41 : 32) &&
    instr.clkMax == (instr.wide ? 43 : 34))
    else $error("memory multiply timing wrong");
  imm_extend_a: assert property (
    instrValid && instr.opcode == 8'h83 |->
    instr.imm[15:8] == {8{instr.imm[7]}})
    else $error("short immediate not sign-extended");

endmodule
`default_nettype wire

// ===== rtl/aodt_pkg.sv
/*
  Shared constants and types for the arithmetic opcode decoder: opcode
  patterns, modrm fields, execution clock counts, the decoded word and
  the clock-count lookup that the decoder applies at issue.
  Assumes one processor clock; clock counts are in processor clocks.
*/
package aodt_pkg;

  // ------------------------------------------------------------------
  // opcode patterns
  // ------------------------------------------------------------------
  localparam logic [7:0] OPC_SEG_EXTRA = 8'h26;
  localparam logic [7:0] OPC_SEG_CODE  = 8'h2e;
  localparam logic [7:0] OPC_SEG_STACK = 8'h36;
  localparam logic [7:0] OPC_SEG_DATA  = 8'h3e;
  localparam logic [7:0] OPC_UBCD_ADD  = 8'h37;
  localparam logic [7:0] OPC_PBCD_ADD  = 8'h27;
  localparam logic [7:0] OPC_UBCD_SUB  = 8'h3f;
  localparam logic [7:0] OPC_PBCD_SUB  = 8'h2f;
  // upper six bits of the register/modrm forms
  localparam logic [5:0] REG_ADD       = 6'h00;
  localparam logic [5:0] REG_ADC       = 6'h04;
  localparam logic [5:0] REG_SUB       = 6'h0a;
  localparam logic [5:0] REG_SUBB      = 6'h06;
  localparam logic [5:0] IMM_GROUP     = 6'h20;
  // upper seven bits of the accumulator forms and the unary group
  localparam logic [6:0] ACC_ADD       = 7'h02;
  localparam logic [6:0] ACC_ADC       = 7'h0a;
  localparam logic [6:0] ACC_SUB       = 7'h16;
  localparam logic [6:0] ACC_SUBB      = 7'h0e;
  localparam logic [6:0] UNARY_GROUP   = 7'h7b;
  // modrm reg field selectors
  localparam logic [2:0] SEL_ADD       = 3'h0;
  localparam logic [2:0] SEL_ADC       = 3'h2;
  localparam logic [2:0] SEL_SUBB      = 3'h3;
  localparam logic [2:0] SEL_SUB       = 3'h5;
  localparam logic [2:0] SEL_NEGATE    = 3'h3;
  localparam logic [2:0] SEL_MULTIPLY  = 3'h4;
  localparam logic [2:0] SEL_TEST      = 3'h1;
  localparam logic [1:0] MOD_REGISTER  = 2'h3;
  localparam logic [1:0] MOD_DISP8     = 2'h1;
  localparam logic [1:0] MOD_DISP16    = 2'h2;
  localparam logic [2:0] RM_DIRECT     = 3'h6;

  // ------------------------------------------------------------------
  // execution clocks
  // ------------------------------------------------------------------
  localparam int         CLK_W         = 6;
  localparam logic [CLK_W-1:0] CLK_SEG_PREFIX = 6'h02;
  localparam logic [CLK_W-1:0] CLK_ALU_REG    = 6'h03;
  localparam logic [CLK_W-1:0] CLK_ALU_MEM    = 6'h0a;
  localparam logic [CLK_W-1:0] CLK_IMM_REG    = 6'h04;
  localparam logic [CLK_W-1:0] CLK_IMM_MEM    = 6'h10;
  localparam logic [CLK_W-1:0] CLK_ACC_BYTE   = 6'h03;
  localparam logic [CLK_W-1:0] CLK_ACC_WORD   = 6'h04;
  localparam logic [CLK_W-1:0] CLK_NEG_REG    = 6'h03;
  localparam logic [CLK_W-1:0] CLK_NEG_MEM    = 6'h0a;
  localparam logic [CLK_W-1:0] CLK_UBCD_ADD   = 6'h08;
  localparam logic [CLK_W-1:0] CLK_PBCD_ADD   = 6'h04;
  localparam logic [CLK_W-1:0] CLK_UBCD_SUB   = 6'h07;
  localparam logic [CLK_W-1:0] CLK_PBCD_SUB   = 6'h04;
  localparam logic [CLK_W-1:0] CLK_MPY_RB_MIN = 6'h1a;
  localparam logic [CLK_W-1:0] CLK_MPY_RB_MAX = 6'h1c;
  localparam logic [CLK_W-1:0] CLK_MPY_RW_MIN = 6'h23;
  localparam logic [CLK_W-1:0] CLK_MPY_RW_MAX = 6'h25;
  localparam logic [CLK_W-1:0] CLK_MPY_MB_MIN = 6'h20;
  localparam logic [CLK_W-1:0] CLK_MPY_MB_MAX = 6'h22;
  localparam logic [CLK_W-1:0] CLK_MPY_MW_MIN = 6'h29;
  localparam logic [CLK_W-1:0] CLK_MPY_MW_MAX = 6'h2b;
  localparam logic [CLK_W-1:0] CLK_UNKNOWN    = 6'h01;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    opNone, opAdd, opAddCarry, opSub, opSubtractionWithBorrowIn,
    opTwosComplementNegate, opUnsignedMultiply,
    opUnpackedBcdFixAfterAdd, opPackedBcdFixAfterAdd,
    opUnpackedBcdFixAfterSub, opPackedBcdFixAfterSub
  } aodt_op_t;

  typedef enum logic [2:0] {
    fmNone, fmRegRm, fmImmGroup, fmAccum, fmUnary, fmSingle
  } aodt_form_t;

  typedef enum logic [1:0] {
    segExtra, segCode, segStack, segData
  } aodt_seg_t;

  typedef enum logic [1:0] {
    stOpcode, stModrm, stDisp, stImm
  } aodt_state_t;

  typedef struct packed {
    aodt_op_t         op;
    aodt_form_t       form;
    logic [7:0]       opcode;
    logic [7:0]       modrm;
    logic             wide;
    logic             toReg;
    logic             memOperand;
    logic             segValid;
    aodt_seg_t        seg;
    logic             useCarry;
    logic             carryIsBorrow;
    logic [15:0]      disp;
    logic [15:0]      imm;
    logic [CLK_W-1:0] clkMin;
    logic [CLK_W-1:0] clkMax;
  } aodt_instr_t;

  // ------------------------------------------------------------------
  // timing lookup
  // ------------------------------------------------------------------
  // multiply time depends on operand data, so both ends are reported
  function automatic aodt_instr_t applyTiming(input aodt_instr_t i);
    aodt_instr_t t;
    t = i;
    t.clkMax = CLK_UNKNOWN;
    case (i.op)
      opAdd, opAddCarry, opSub, opSubtractionWithBorrowIn:
      begin
        if (i.form == fmRegRm)
          t.clkMax = i.memOperand ? CLK_ALU_MEM : CLK_ALU_REG;
        else if (i.form == fmImmGroup)
          t.clkMax = i.memOperand ? CLK_IMM_MEM : CLK_IMM_REG;
        else
          t.clkMax = i.wide ? CLK_ACC_WORD : CLK_ACC_BYTE;
      end
      opTwosComplementNegate:
        t.clkMax = i.memOperand ? CLK_NEG_MEM : CLK_NEG_REG;
      opUnpackedBcdFixAfterAdd: t.clkMax = CLK_UBCD_ADD;
      opPackedBcdFixAfterAdd:   t.clkMax = CLK_PBCD_ADD;
      opUnpackedBcdFixAfterSub: t.clkMax = CLK_UBCD_SUB;
      opPackedBcdFixAfterSub:   t.clkMax = CLK_PBCD_SUB;
      opUnsignedMultiply:
      begin
        if (!i.memOperand)
          t.clkMax = i.wide ? CLK_MPY_RW_MAX : CLK_MPY_RB_MAX;
        else
          t.clkMax = i.wide ? CLK_MPY_MW_MAX : CLK_MPY_MB_MAX;
      end
      default: t.clkMax = CLK_UNKNOWN;
    endcase
    t.clkMin = t.clkMax;
    if (i.op == opUnsignedMultiply)
    begin
      if (!i.memOperand)
        t.clkMin = i.wide ? CLK_MPY_RW_MIN : CLK_MPY_RB_MIN;
      else
        t.clkMin = i.wide ? CLK_MPY_MW_MIN : CLK_MPY_MB_MIN;
    end
    return t;
  endfunction

endpackage

// ===== rtl/aodt_exec_timer.sv
/*
  Execution clock counter: loads a clock count and holds busy for that
  many cycles, then pulses done. Assumes load is a one-cycle strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module aodt_exec_timer
  import aodt_pkg::*;
#(
  parameter int WIDTH = CLK_W
)
(
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output logic                  busy,
  output logic                  done
);

  if (WIDTH < CLK_W)
  begin : gWidthCheck
    $error("timer width too small for the longest clock count");
  end

  logic [WIDTH-1:0] countReg;
  logic [WIDTH-1:0] countNext;
  logic             doneReg;
  logic             doneNext;

  // ------------------------------------------------------------------
  // countdown
  // ------------------------------------------------------------------
  // a new load always wins, so back-to-back issues never merge
  always_comb
  begin
    countNext = countReg;
    if (load)
      countNext = count;
    else if (countReg != '0)
      countNext = WIDTH'(countReg - 1'b1);
    doneNext = (countReg == WIDTH'(1)) && !load;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      countReg <= '0;
      doneReg  <= 1'b0;
    end
    else
    begin
      countReg <= countNext;
      doneReg  <= doneNext;
    end
  end

  assign busy = (countReg != '0);
  assign done = doneReg;

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  done_follows_a: assert property (done |-> $past(countReg) == WIDTH'(1))
    else $error("done without a final count");

endmodule
`default_nettype wire

// ===== dv/aodt_prefetch_model.sv
/*
  prefetch queue model: hands bytes to the decoder on request.
  assumes one clock and a bench that pushes bytes and drives stall.
*/
`timescale 1ns/1ps
`default_nettype none
module aodt_prefetch_model
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       byteReady,
  input  wire logic       stall,
  output logic [7:0]      byteData,
  output logic            byteValid
);
  // ----------------------------------------------------------------
  // byte queue
  // ----------------------------------------------------------------
  logic [7:0] fifo[$];
  logic       tk;
  initial
  begin
    byteData = 8'h00;
    byteValid = 1'b0;
  end
  task automatic push(input logic [7:0] b);
    fifo.push_back(b);
  endtask
  // an offered byte is held until taken; stall only delays a fresh one
  always @(posedge clock)
  begin
    tk = byteValid && byteReady;
    #1;
    if (tk)
      void'(fifo.pop_front());
    byteValid = arst_n && fifo.size() != 0 && ((byteValid && !tk) || !stall);
    byteData = byteValid ? fifo[0] : ~byteData; // idle data is junk
  end
endmodule
`default_nettype wire

// ===== dv/arith_opcode_decode_timing_bench.sv
/*
  self-checking bench for aodt_decoder: opcode forms, clocks, immediates.
  assumes the prefetch model and a 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module arith_opcode_decode_timing_bench
  import aodt_pkg::*;
;
  logic        clock;
  logic        arst_n;
  logic        stall = 1'b0;
  logic [7:0]  byteData;
  logic        byteValid;
  logic        byteReady;
  aodt_instr_t instr;
  logic        instrValid;
  logic        busy;
  logic        execDone;
  int          fail_count;
  int          total_checks;
  logic [16:0] seed;
  logic [16:0] sr = 17'd67422;
  // ----------------------------------------------------------------
  // harness
  // ----------------------------------------------------------------
  aodt_decoder u_dut (.clock(clock), .arst_n(arst_n), .byteData(byteData),
    .byteValid(byteValid), .byteReady(byteReady), .instr(instr),
    .instrValid(instrValid), .busy(busy), .execDone(execDone));
  aodt_prefetch_model u_src (.clock(clock), .arst_n(arst_n),
    .byteReady(byteReady), .stall(stall), .byteData(byteData),
    .byteValid(byteValid));
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  // random source stalls so offers are not always back to back
  always @(posedge clock)
  begin
    sr <= lfsr(sr);
    stall <= sr[0] & sr[3];
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("Error %0t %s", $time, m);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // issue n bytes, then compare decode and the busy span
  task automatic run(input int n, input logic [31:0] b, input aodt_op_t op,
    input int mn, input int mx, input logic ci, input logic [15:0] im);
    int k;
    for (k = 0; k < n; k++) u_src.push(b[31-8*k -: 8]);
    k = 0;
    while (instrValid !== 1'b1 && k < 40)
    begin
      @(posedge clock);
      #1 k++;
    end
    chk(instrValid === 1'b1 && instr.op === op, "op");
    chk(instr.clkMax === 6'(mx) && instr.clkMin === 6'(mn), "clk");
    if (ci)
      chk(instr.imm === im, "imm");
    k = 0;
    while (busy === 1'b1 && k < 60)
    begin
      chk(byteReady === 1'b0, "ready while busy");
      @(posedge clock);
      #1 k++;
    end
    chk(k == mx && execDone === 1'b1 && byteReady === 1'b1, "busy span");
    $display("test %h done", b);
  endtask
  // prefix: no issue, two busy clocks, then override on the next add
  task automatic prefix(input logic [7:0] p, input aodt_seg_t s);
    int k;
    u_src.push(p);
    k = 0;
    while (busy !== 1'b1 && k < 20)
    begin
      @(posedge clock);
      #1 k++;
      chk(instrValid === 1'b0, "prefix issued");
    end
    k = 0;
    while (busy === 1'b1 && k < 20)
    begin
      @(posedge clock);
      #1 k++;
    end
    chk(k == 2, "prefix clocks");
    run(2, 32'h00c0_0000, opAdd, 3, 3, 0, 0);
    chk(instr.segValid === 1'b1 && instr.seg === s, "segment");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    arst_n = 1'b0;
    fail_count = 0;
    total_checks = 0;
    seed = 17'd67422;
    repeat (5) @(posedge clock);
    #1;
    chk(byteReady === 1'b1 && busy === 1'b0 && instrValid === 1'b0 &&
        execDone === 1'b0, "reset values");
    arst_n = 1'b1;
    prefix(8'h26, segExtra);
    prefix(8'h2e, segCode);
    prefix(8'h36, segStack);
    prefix(8'h3e, segData);
    run(2, 32'h0405_0000, opAdd, 3, 3, 1, 16'h0005);
    chk(instr.segValid === 1'b0, "override kept");
    run(3, 32'h80d0_7f00, opAddCarry, 4, 4, 1, 16'h007f);
    run(4, 32'h8110_3412, opAddCarry, 16, 16, 1, 16'h1234);
    run(3, 32'h2d34_1200, opSub, 4, 4, 1, 16'h1234);
    run(2, 32'h2c01_0000, opSub, 3, 3, 0, 0);
    run(3, 32'h1246_0500, opAddCarry, 10, 10, 0, 0);
    chk(instr.disp === 16'h0005 && instr.memOperand === 1'b1, "disp8");
    run(3, 32'h1534_1200, opAddCarry, 4, 4, 1, 16'h1234);
    run(4, 32'h8356_1080, opAddCarry, 16, 16, 1, 16'hff80);
    run(4, 32'h2906_3412, opSub, 10, 10, 0, 0);
    chk(instr.disp === 16'h1234, "disp16");
    run(3, 32'h80e8_9000, opSub, 4, 4, 1, 16'h0090);
    run(3, 32'h83d8_8000, opSubtractionWithBorrowIn, 4, 4, 1, 16'hff80);
    run(2, 32'h1c7f_0000, opSubtractionWithBorrowIn, 3, 3, 1, 16'h007f);
    run(2, 32'h18c0_0000, opSubtractionWithBorrowIn, 3, 3, 0, 0);
    chk(instr.useCarry === 1'b1 && instr.carryIsBorrow === 1'b1, "cy");
    run(2, 32'hf7d8_0000, opTwosComplementNegate, 3, 3, 0, 0);
    run(2, 32'hf618_0000, opTwosComplementNegate, 10, 10, 0, 0);
    // second byte waits behind the busy span and is taken as it ends
    run(2, 32'h3727_0000, opUnpackedBcdFixAfterAdd, 8, 8, 0, 0);
    run(0, 32'h0, opPackedBcdFixAfterAdd, 4, 4, 0, 0);
    run(1, 32'h3f00_0000, opUnpackedBcdFixAfterSub, 7, 7, 0, 0);
    run(1, 32'h2f00_0000, opPackedBcdFixAfterSub, 4, 4, 0, 0);
    run(2, 32'hf6e1_0000, opUnsignedMultiply, 26, 28, 0, 0);
    run(2, 32'hf7e1_0000, opUnsignedMultiply, 35, 37, 0, 0);
    run(2, 32'hf620_0000, opUnsignedMultiply, 32, 34, 0, 0);
    run(2, 32'hf720_0000, opUnsignedMultiply, 41, 43, 0, 0);
    run(3, 32'h83c0_ff00, opAdd, 4, 4, 1, 16'hffff);
    repeat (8)
    begin
      seed = lfsr(seed);
      run(3, {16'h83c0, seed[7:0], 8'h00}, opAdd, 4, 4, 1,
        16'(signed'(seed[7:0])));
      run(3, {8'h05, seed[7:0], seed[15:8], 8'h00}, opAdd, 4, 4, 1,
        seed[15:0]);
    end
    summarize();
  end
  initial
  begin
    #(40 * 20000);
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
